// File: design/rre_exec.v
`timescale 1ns/1ps
`include "rre_regs.vh"

// Behaviour
// - Return-from-interrupt pops stack top into counter.
// - Return-from-interrupt sets high or low enable.
// - Shadow flag set restores accumulator, status, bank.
// - Return-with-literal loads literal, no flags.
// - Return-with-literal pops stack, takes two cycles.
// - Returns never touch counter high/upper latches.
// - Return-from-subroutine pops stack into counter.
// - Subroutine shadow flag set restores three registers.
// - Rotate left through carry, update C N Z.
// - Dest bit picks accumulator/file, access picks bank.
module rre_exec (
    input wire clk,
    input wire resetn,
    input wire instr_valid,
    input wire [15:0] instr,
    input wire [7:0] file_rdata,
    input wire push_valid,
    input wire [20:0] push_addr,
    input wire [7:0] accumulator_shadow,
    input wire [4:0] status_shadow,
    input wire [3:0] bank_select_shadow,
    input wire irq_level_low,
    input wire latch_wr,
    input wire latch_sel_upper,
    input wire [7:0] latch_wdata,
    output reg [1:0] q_phase,
    output reg [20:0] pc,
    output reg [7:0] accumulator,
    output reg [4:0] status,
    output reg [3:0] bank_select_register,
    output reg global_irq_enable_high,
    output reg peripheral_irq_enable_low,
    output reg [7:0] pc_latch_high,
    output reg [4:0] pc_latch_upper,
    output reg [4:0] stack_ptr,
    output reg bubble,
    output reg [11:0] file_addr,
    output reg [7:0] file_wdata,
    output reg file_we
);

    // Decoded instruction held for the whole instruction cycle.
    reg [15:0] op;
    reg op_valid;
    reg [7:0] file_value;
    reg [20:0] stack_mem [0:`RRE_STACK_DEPTH-1];

    // Opcode decode of the held word. Any other opcode only lets the
    // counter step, which keeps a stray word harmless.
    wire is_irq_ret = op_valid && (op[15:1] == `RRE_OP_IRQ_RET_HI);
    wire is_return = op_valid && (op[15:1] == `RRE_OP_RETURN_HI);
    wire is_lit_ret = op_valid && (op[15:8] == `RRE_OP_LIT_RET_HI);
    wire is_rot_carry = op_valid && (op[15:10] == `RRE_OP_ROT_CARRY_HI);
    wire is_ret = is_irq_ret || is_return || is_lit_ret;
    // The shadow flag shares bit 0 with the literal, so only the two
    // returns that define it may honour it.
    wire shadow_flag = op[`RRE_BIT_SHADOW];
    wire dest_file = op[`RRE_BIT_DEST];

    // Stack top is the entry below the pointer; an empty stack reads zero.
    wire [4:0] top_index = stack_ptr - 5'h01;
    wire [20:0] stack_top = (stack_ptr == `RRE_SP_EMPTY) ? `RRE_RST_PC : stack_mem[top_index];

    // Rotate result uses the file value captured in the read phase.
    wire [7:0] rot_result = {file_value[6:0], status[`RRE_ST_C]};
    wire rot_carry = file_value[7];

    // Free-running phase counter; one instruction cycle is four clocks.
    // It is never held, so every phase decision can rely on a fixed cadence.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_phase <= `RRE_Q1;
        end else begin
            q_phase <= q_phase + 2'h1;
        end
    end

    // Instruction capture at the first phase. A word offered during the
    // bubble was fetched from the old stream and is thrown away.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op <= 16'h0000;
            op_valid <= 1'b0;
        end else if (q_phase == `RRE_Q1) begin
            op <= instr;
            op_valid <= instr_valid && !bubble;
        end
    end

    // Bubble covers the instruction cycle right after any return.
    // Holding it a full cycle keeps capture and counter quiet while fetch refills.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bubble <= 1'b0;
        end else if (q_phase == `RRE_Q4) begin
            bubble <= is_ret;
        end
    end

    // File register access: bank comes from the access bank split or the
    // bank-select register, and the operand is sampled in the read phase.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            file_addr <= 12'h000;
            file_value <= `RRE_RST_BYTE;
        end else begin
            if (q_phase == `RRE_Q1) begin
                if (instr[`RRE_BIT_ACCESS]) begin
                    file_addr <= {bank_select_register, instr[7:0]};
                end else if (instr[7:0] >= `RRE_ACCESS_SPLIT) begin
                    file_addr <= {`RRE_ACCESS_HIGH_BANK, instr[7:0]};
                end else begin
                    file_addr <= {`RRE_ACCESS_LOW_BANK, instr[7:0]};
                end
            end
            if (q_phase == `RRE_Q2) begin
                file_value <= file_rdata;
            end
        end
    end

    // The file write strobe is raised so it stands exactly in the last phase.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            file_we <= 1'b0;
            file_wdata <= `RRE_RST_BYTE;
        end else begin
            file_we <= (q_phase == `RRE_Q3) && is_rot_carry && dest_file;
            if (q_phase == `RRE_Q3) begin
                file_wdata <= rot_result;
            end
        end
    end

    // Stack storage: pushes come from the call logic outside. A pop in the
    // same clock wins, and the push offered in that clock is dropped.
    always @(posedge clk) begin
        if (push_valid && !(q_phase == `RRE_Q4 && is_ret) && stack_ptr != `RRE_SP_FULL) begin
            stack_mem[stack_ptr] <= push_addr;
        end
    end

    // Stack pointer and program counter.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stack_ptr <= `RRE_SP_EMPTY;
            pc <= `RRE_RST_PC;
        end else if (q_phase == `RRE_Q4 && is_ret) begin
            pc <= stack_top;
            // An empty stack pops as zero and the pointer does not wrap.
            if (stack_ptr != `RRE_SP_EMPTY) begin
                stack_ptr <= top_index;
            end
        end else begin
            if (push_valid && stack_ptr != `RRE_SP_FULL) begin
                stack_ptr <= stack_ptr + 5'h01;
            end
            if (q_phase == `RRE_Q4 && !bubble) begin
                pc <= pc + `RRE_PC_STEP;
            end
        end
    end

    // Working registers. Only the rotate computes flags; returns restore
    // from shadows only when the shadow flag is set.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accumulator <= `RRE_RST_BYTE;
            status <= `RRE_RST_STATUS;
            bank_select_register <= `RRE_RST_BANK;
        end else if (q_phase == `RRE_Q4) begin
            if ((is_irq_ret || is_return) && shadow_flag) begin
                accumulator <= accumulator_shadow;
                status <= status_shadow;
                bank_select_register <= bank_select_shadow;
            end else if (is_lit_ret) begin
                accumulator <= op[7:0];
            end else if (is_rot_carry) begin
                if (!dest_file) begin
                    accumulator <= rot_result;
                end
                status[`RRE_ST_C] <= rot_carry;
                status[`RRE_ST_Z] <= (rot_result == 8'h00);
                status[`RRE_ST_N] <= rot_result[7];
            end
        end
    end

    // Interrupt enables: set on interrupt return only, by priority level.
    // Nothing here clears them; that belongs to the interrupt entry logic.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            global_irq_enable_high <= 1'b0;
            peripheral_irq_enable_low <= 1'b0;
        end else if (q_phase == `RRE_Q4 && is_irq_ret) begin
            if (irq_level_low) begin
                peripheral_irq_enable_low <= 1'b1;
            end else begin
                global_irq_enable_high <= 1'b1;
            end
        end
    end

    // Counter latches change only through their own write port, so a
    // return never disturbs them.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_latch_high <= `RRE_RST_BYTE;
            pc_latch_upper <= 5'h00;
        end else if (latch_wr) begin
            if (latch_sel_upper) begin
                pc_latch_upper <= latch_wdata[4:0];
            end else begin
                pc_latch_high <= latch_wdata;
            end
        end
    end

endmodule // rre_exec

// File: common/rre_regs.vh
`ifndef RRE_REGS_VH
`define RRE_REGS_VH

// Opcode patterns, compared against the upper instruction bits.
`define RRE_OP_IRQ_RET_HI 15'h0008
`define RRE_OP_RETURN_HI 15'h0009
`define RRE_OP_LIT_RET_HI 8'h0C
`define RRE_OP_ROT_CARRY_HI 6'h0D

// Instruction field positions.
`define RRE_BIT_SHADOW 0
`define RRE_BIT_ACCESS 8
`define RRE_BIT_DEST 9

// Status register bit positions.
`define RRE_ST_C 0
`define RRE_ST_Z 2
`define RRE_ST_N 4

// Phase codes of the four-phase instruction cycle.
`define RRE_Q1 2'h0
`define RRE_Q2 2'h1
`define RRE_Q3 2'h2
`define RRE_Q4 2'h3

// Return stack geometry and access bank split.
`define RRE_STACK_DEPTH 31
`define RRE_SP_EMPTY 5'h00
`define RRE_SP_FULL 5'h1F
`define RRE_ACCESS_SPLIT 8'h60
`define RRE_ACCESS_LOW_BANK 4'h0
`define RRE_ACCESS_HIGH_BANK 4'hF

// Reset values and program counter step.
`define RRE_RST_PC 21'h000000
`define RRE_RST_BYTE 8'h00
`define RRE_RST_BANK 4'h0
`define RRE_RST_STATUS 5'h00
`define RRE_PC_STEP 21'h000002

`endif

// File: tb/rre_exec_sva.sv
`timescale 1ns/1ps
// Port-level checks of phase, stack, bubble and enable behaviour.
module rre_exec_sva (
    input wire clk,
    input wire resetn,
    input wire [1:0] q_phase,
    input wire [20:0] pc,
    input wire [4:0] stack_ptr,
    input wire bubble,
    input wire file_we,
    input wire latch_wr,
    input wire [7:0] pc_latch_high,
    input wire [4:0] pc_latch_upper,
    input wire global_irq_enable_high,
    input wire peripheral_irq_enable_low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // A skipped phase would shift every write strobe.
    a_phase_step: assert property (1 |=> q_phase == $past(q_phase) + 2'h1) else $error("phase skipped");
    a_we_phase: assert property (file_we |-> q_phase == 2'h3) else $error("write outside last phase");
    a_we_pulse: assert property (file_we |=> !file_we) else $error("write strobe too long");
    a_latch_keep: assert property (!latch_wr |=> $stable(pc_latch_high) && $stable(pc_latch_upper))
        else $error("latch moved");
    a_pop_level: assert property ($rose(bubble) && $past(stack_ptr) != 5'h00
        |-> stack_ptr == $past(stack_ptr) - 5'h01) else $error("pop level wrong");
    a_bubble_len: assert property ($rose(bubble) |-> bubble [*4] ##1 !bubble) else $error("bubble length");
    a_pc_hold: assert property ($rose(bubble) |=> $stable(pc) [*3]) else $error("pc moved in bubble");
    a_irq_cause: assert property ($rose(global_irq_enable_high) || $rose(peripheral_irq_enable_low)
        |-> $rose(bubble)) else $error("enable set without return");
    a_irq_sticky: assert property (!$fell(global_irq_enable_high) && !$fell(peripheral_irq_enable_low))
        else $error("enable cleared");
endmodule // rre_exec_sva

// File: tb/test_return_and_rotate_exec.sv
`timescale 1ns/1ps
module test_return_and_rotate_exec;
    // All inputs start defined; shadows differ from live values so a restore shows.
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg instr_valid = 1'b0;
    reg [15:0] instr = 16'h0000;
    reg [7:0] file_rdata = 8'h00;
    reg push_valid = 1'b0;
    reg [20:0] push_addr = 21'h000000;
    reg [7:0] accumulator_shadow = 8'h3C;
    reg [4:0] status_shadow = 5'h0A;
    reg [3:0] bank_select_shadow = 4'h7;
    reg irq_level_low = 1'b0;
    reg latch_wr = 1'b0;
    reg latch_sel_upper = 1'b0;
    reg [7:0] latch_wdata = 8'h00;
    wire [1:0] q_phase;
    wire [20:0] pc;
    wire [7:0] accumulator, pc_latch_high, file_wdata;
    wire [4:0] status, pc_latch_upper, stack_ptr;
    wire [3:0] bank_select_register;
    wire global_irq_enable_high, peripheral_irq_enable_low, bubble, file_we;
    wire [11:0] file_addr;
    integer n_mismatch = 0;
    integer tests_run = 0;
    integer i;
    integer n_we = 0;
    // Holds the offered word past its capture edge, so it also stands at the first edge of the bubble.
    reg keep_offer = 1'b0;
    always #2.5 clk = ~clk;
    // Counts file write strobes at the falling edge, away from the edge that launches them.
    always @(negedge clk) begin
        if (file_we === 1'b1) n_we <= n_we + 1;
    end
    rre_exec u_rre_exec (.clk, .resetn, .instr_valid, .instr, .file_rdata, .push_valid, .push_addr,
        .accumulator_shadow, .status_shadow, .bank_select_shadow, .irq_level_low, .latch_wr, .latch_sel_upper,
        .latch_wdata, .q_phase, .pc, .accumulator, .status, .bank_select_register, .global_irq_enable_high,
        .peripheral_irq_enable_low, .pc_latch_high, .pc_latch_upper, .stack_ptr, .bubble, .file_addr,
        .file_wdata, .file_we);
    task stop_test;
        begin
            $display("compares %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
            end
        end
    endtask
    // Offers one word in the Q1 clock, ahead of its capture edge, skipping bubbles; results are read after the Q4 edge.
    task op(input [15:0] w, input [7:0] fd);
        integer k;
        begin
            k = 0;
            @(negedge clk);
            while (!(q_phase === 2'h3 && bubble === 1'b0)) begin
                @(negedge clk);
                k = k + 1;
                if (k > 20) begin
                    n_mismatch = n_mismatch + 1;
                    stop_test;
                end
            end
            @(posedge clk);
            instr_valid <= 1'b1;
            instr <= w;
            file_rdata <= fd;
            @(posedge clk);
            instr_valid <= keep_offer;
            repeat (3) @(posedge clk);
            @(negedge clk);
            $display("test %h done", w);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        latch_wr <= 1'b1;
        latch_wdata <= 8'hA5;
        @(posedge clk);
        latch_sel_upper <= 1'b1;
        latch_wdata <= 8'h13;
        for (i = 1; i < 4; i = i + 1) begin
            @(posedge clk);
            latch_wr <= 1'b0;
            push_valid <= 1'b1;
            push_addr <= {i[12:0], 8'h00};
        end
        @(posedge clk);
        push_valid <= 1'b0;
        @(negedge clk);
        chk("stack_ptr", 3, stack_ptr);
        op(16'h3470, 8'h80);
        chk("file_addr", 12'hF70, file_addr);
        chk("accumulator", 8'h00, accumulator);
        chk("status", 5'h05, status);
        chk("file_we count", 0, n_we);
        op(16'h3620, 8'h40);
        chk("file_wdata", 8'h81, file_wdata);
        chk("status", 5'h10, status);
        chk("file_addr", 12'h020, file_addr);
        chk("accumulator", 8'h00, accumulator);
        chk("file_we count", 1, n_we);
        keep_offer = 1'b1;
        op(16'h0C5A, 8'h00);
        keep_offer = 1'b0;
        chk("accumulator", 8'h5A, accumulator);
        chk("status", 5'h10, status);
        chk("pc", 21'h000300, pc);
        chk("stack_ptr", 2, stack_ptr);
        chk("bubble", 1, bubble);
        @(posedge clk);
        instr_valid <= 1'b0;
        op(16'h0013, 8'h00);
        chk("pc", 21'h000200, pc);
        chk("stack_ptr", 1, stack_ptr);
        chk("accumulator", 8'h3C, accumulator);
        chk("status", 5'h0A, status);
        chk("bank", 4'h7, bank_select_register);
        op(16'h3730, 8'h01);
        chk("file_addr", 12'h730, file_addr);
        chk("file_wdata", 8'h02, file_wdata);
        chk("status", 5'h0A, status);
        chk("file_we count", 2, n_we);
        @(posedge clk);
        accumulator_shadow <= 8'hC3;
        op(16'h0010, 8'h00);
        chk("accumulator", 8'h3C, accumulator);
        chk("status", 5'h0A, status);
        chk("pc", 21'h000100, pc);
        chk("irq_high", 1, global_irq_enable_high);
        chk("irq_low", 0, peripheral_irq_enable_low);
        chk("stack_ptr", 0, stack_ptr);
        @(posedge clk);
        irq_level_low <= 1'b1;
        op(16'h0011, 8'h00);
        chk("accumulator", 8'hC3, accumulator);
        chk("pc", 21'h000000, pc);
        chk("stack_ptr", 0, stack_ptr);
        chk("irq_low", 1, peripheral_irq_enable_low);
        chk("latch_high", 8'hA5, pc_latch_high);
        chk("latch_upper", 5'h13, pc_latch_upper);
        stop_test;
    end
endmodule // test_return_and_rotate_exec
bind rre_exec rre_exec_sva u_rre_exec_sva (.clk, .resetn, .q_phase, .pc, .stack_ptr, .bubble, .file_we, .latch_wr,
    .pc_latch_high, .pc_latch_upper, .global_irq_enable_high, .peripheral_irq_enable_low);
